// ---- core/dmb_addr_gen.sv ----
// Combinational address former and window check for one data access
`timescale 1ns/10ps
module dmb_addr_gen (
    input  wire logic              i_emb,
    input  wire logic [3:0]        i_smb,
    input  wire dmb_pkg::dmb_mode_t i_mode,
    input  wire logic              i_byte,
    input  wire logic [7:0]        i_da,
    input  wire logic [9:0]        i_memb,
    input  wire logic [1:0]        i_bit_idx,
    input  wire logic [3:0]        i_reg_h,
    input  wire logic [3:0]        i_reg_l,
    input  wire logic [3:0]        i_reg_w,
    input  wire logic [3:0]        i_reg_x,
    input  wire logic [7:0]        i_sp,
    output logic      [11:0]       o_addr,
    output logic      [1:0]        o_bit,
    output logic                   o_ok
);

    logic [7:0] low;
    logic [3:0] bank;

    // Address and permission per mode
    always_comb begin
        low  = i_da;
        bank = dmb_pkg::BANK0;
        o_bit = i_bit_idx;
        o_ok  = 1'b1;
        case (i_mode)
            dmb_pkg::MODE_DIRECT: begin
                low = i_da;
                if (i_emb) begin
                    bank = i_smb;
                    o_ok = (i_smb != dmb_pkg::BANK15) || (i_da >= dmb_pkg::DIRECT_SPLIT);
                end else begin
                    // split between bank 0 and 15
                    bank = (i_da < dmb_pkg::DIRECT_SPLIT) ? dmb_pkg::BANK0 : dmb_pkg::BANK15;
                end
            end
            dmb_pkg::MODE_IND_HL: begin
                low = {i_reg_h, i_reg_l};
                if (i_emb) begin
                    bank = i_smb;
                    o_ok = (i_smb != dmb_pkg::BANK15) || (low >= dmb_pkg::DIRECT_SPLIT);
                end else begin
                    bank = dmb_pkg::BANK0;
                end
            end
            dmb_pkg::MODE_IND_WX: begin
                low  = {i_reg_w, i_reg_x};
                bank = dmb_pkg::BANK0;
            end
            dmb_pkg::MODE_IND_WL: begin
                low  = {i_reg_w, i_reg_l};
                bank = dmb_pkg::BANK0;
            end
            dmb_pkg::MODE_IND_SP: begin
                low  = i_sp;
                bank = dmb_pkg::BANK0;
            end
            dmb_pkg::MODE_BIT_MEMA: begin
                low  = i_da;
                bank = dmb_pkg::BANK15;
                o_ok = (i_da[7:4] == dmb_pkg::MEMA_NIB_A) || (i_da[7:4] == dmb_pkg::MEMA_NIB_B);
            end
            dmb_pkg::MODE_BIT_MEMB_L: begin
                // nibble from memb and L high bits
                {bank, low} = {i_memb, i_reg_l[3:2]};
                o_bit = i_reg_l[1:0];
                o_ok  = ({i_memb, i_reg_l[3:2]} >= dmb_pkg::MEMB_BASE);
            end
            dmb_pkg::MODE_BIT_H_DA: begin
                low = {i_reg_h, i_da[3:0]};
                if (i_emb) begin
                    bank = i_smb;
                    o_ok = (i_smb != dmb_pkg::BANK15) || (low >= dmb_pkg::DIRECT_SPLIT);
                end else begin
                    bank = dmb_pkg::BANK0;
                end
            end
            default: begin
                o_ok = 1'b0;
            end
        endcase
        // byte accesses pair on an even nibble
        if (i_byte) begin
            low[0] = 1'b0;
        end
        o_addr = {bank, low};
    end

endmodule

// ---- core/dmb_bank_addr.sv ----
// Data memory bank select, flag handling and address generation top
`timescale 1ns/10ps
module dmb_bank_addr (
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic               i_boot_load,
    input  wire logic               i_vec_take,
    input  wire logic [7:0]         i_vec_word,
    input  wire logic               i_iret,
    input  wire logic [1:0]         i_iret_flags,
    input  wire logic               i_flag_we,
    input  wire logic               i_flag_sel,
    input  wire logic               i_flag_val,
    input  wire logic               i_smb_we,
    input  wire logic [3:0]         i_smb_val,
    input  wire logic               i_srb_we,
    input  wire logic [1:0]         i_srb_val,
    input  wire logic               i_sb_pop,
    input  wire logic [7:0]         i_sb_pop_data,
    input  wire logic               i_acc_req,
    input  wire logic               i_acc_wr,
    input  wire dmb_pkg::dmb_mode_t i_acc_mode,
    input  wire logic               i_acc_byte,
    input  wire logic [7:0]         i_acc_da,
    input  wire logic [9:0]         i_acc_memb,
    input  wire logic [1:0]         i_bit_idx,
    input  wire logic [3:0]         i_reg_h,
    input  wire logic [3:0]         i_reg_l,
    input  wire logic [3:0]         i_reg_w,
    input  wire logic [3:0]         i_reg_x,
    input  wire logic [7:0]         i_sp,
    input  wire logic [7:0]         i_ram_rdata,
    output logic                    o_emb,
    output logic                    o_erb,
    output logic [3:0]              o_smb,
    output logic [3:0]              o_srb,
    output logic [7:0]              o_sb_push,
    output logic [1:0]              o_work_bank,
    output logic [1:0]              o_stack_flags,
    output logic [11:0]             o_ram_addr,
    output logic [1:0]              o_ram_bit,
    output logic                    o_ram_req,
    output logic                    o_ram_we,
    output logic                    o_acc_denied,
    output logic [7:0]              o_rd_data,
    output logic                    o_rd_valid
);

    typedef struct packed {
        logic        memory_bank_enable_flag;
        logic        register_bank_enable_flag;
        logic [3:0]  register_bank_select;
        logic [3:0]  memory_bank_select;
        logic [1:0]  work_bank;
        logic [1:0]  stk_flags;
        logic [11:0] addr;
        logic [1:0]  bitn;
        logic        req;
        logic        we;
        logic        denied;
        logic        s1_rd;
        logic        s1_ok;
        logic        s2_rd;
        logic        s2_ok;
        logic [7:0]  rdata;
        logic        rd_vld;
    } dmb_state_t;

    dmb_state_t st_r;
    dmb_state_t st_nxt;

    logic [11:0] gen_addr;
    logic [1:0]  gen_bit;
    logic        gen_ok;

    // Address former sees the current enable and bank select
    dmb_addr_gen u_gen (
        .i_emb     (st_r.memory_bank_enable_flag),
        .i_smb     (st_r.memory_bank_select),
        .i_mode    (i_acc_mode),
        .i_byte    (i_acc_byte),
        .i_da      (i_acc_da),
        .i_memb    (i_acc_memb),
        .i_bit_idx (i_bit_idx),
        .i_reg_h   (i_reg_h),
        .i_reg_l   (i_reg_l),
        .i_reg_w   (i_reg_w),
        .i_reg_x   (i_reg_x),
        .i_sp      (i_sp),
        .o_addr    (gen_addr),
        .o_bit     (gen_bit),
        .o_ok      (gen_ok)
    );

    // Next state of flags, bank select and access pipeline
    always_comb begin
        st_nxt = st_r;

        // Flags: boot load first, then interrupt entry, return, bit ops
        if (i_boot_load) begin
            // memory bank enable from word 0000H
            st_nxt.memory_bank_enable_flag = i_vec_word[dmb_pkg::VEC_EMB_BIT];
            // register bank enable from word 0000H
            st_nxt.register_bank_enable_flag = i_vec_word[dmb_pkg::VEC_ERB_BIT];
        end else if (i_vec_take) begin
            st_nxt.stk_flags = {st_r.memory_bank_enable_flag, st_r.register_bank_enable_flag};
            st_nxt.memory_bank_enable_flag = i_vec_word[dmb_pkg::VEC_EMB_BIT];
            st_nxt.register_bank_enable_flag = i_vec_word[dmb_pkg::VEC_ERB_BIT];
        end else if (i_iret) begin
            {st_nxt.memory_bank_enable_flag, st_nxt.register_bank_enable_flag} = i_iret_flags;
        end else if (i_flag_we) begin
            // bit set or clear, no bank check
            if (i_flag_sel == dmb_pkg::FLAG_SEL_EMB) begin
                st_nxt.memory_bank_enable_flag = i_flag_val;
            end else begin
                st_nxt.register_bank_enable_flag = i_flag_val;
            end
        end

        // Bank select register writes; pop restores the memory bank field and only the low two bits of the register bank field
        if (i_sb_pop) begin
            st_nxt.register_bank_select = {2'b00, i_sb_pop_data[dmb_pkg::SB_SRB_LSB +: 2]};
            st_nxt.memory_bank_select = i_sb_pop_data[dmb_pkg::SB_SMB_MSB:dmb_pkg::SB_SMB_LSB];
        end else begin
            if (i_srb_we) begin
                // only 0 to 3 can be stored
                st_nxt.register_bank_select = {2'b00, i_srb_val};
            end
            // only the four legal banks are taken
            if (i_smb_we && (i_smb_val == dmb_pkg::BANK0 || i_smb_val == dmb_pkg::BANK1 ||
                             i_smb_val == dmb_pkg::BANK2 || i_smb_val == dmb_pkg::BANK15)) begin
                st_nxt.memory_bank_select = i_smb_val;
            end
        end

        // working bank forced to 0 when disabled
        st_nxt.work_bank = st_nxt.register_bank_enable_flag ? st_nxt.register_bank_select[1:0] : dmb_pkg::WORK_BANK_RST;

        // Stage 1: address out, write gated by window
        st_nxt.addr   = gen_addr;
        st_nxt.bitn   = gen_bit;
        st_nxt.req    = i_acc_req && gen_ok;
        st_nxt.we     = i_acc_req && i_acc_wr && gen_ok;
        st_nxt.denied = i_acc_req && !gen_ok;
        st_nxt.s1_rd  = i_acc_req && !i_acc_wr;
        st_nxt.s1_ok  = gen_ok;

        // Stage 2: memory answers on i_ram_rdata
        st_nxt.s2_rd  = st_r.s1_rd;
        st_nxt.s2_ok  = st_r.s1_ok;

        // Stage 3: read result, zero when denied
        st_nxt.rd_vld = st_r.s2_rd;
        if (st_r.s2_rd) begin
            st_nxt.rdata = st_r.s2_ok ? i_ram_rdata : dmb_pkg::RDATA_ZERO;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r           <= '0;
            st_r.register_bank_select       <= dmb_pkg::SRB_RST;
            st_r.memory_bank_select       <= dmb_pkg::SMB_RST;
            st_r.work_bank <= dmb_pkg::WORK_BANK_RST;
            st_r.rdata     <= dmb_pkg::RDATA_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_emb         = st_r.memory_bank_enable_flag;
    assign o_erb         = st_r.register_bank_enable_flag;
    assign o_smb         = st_r.memory_bank_select;
    assign o_srb         = st_r.register_bank_select;
    // register bank field high, memory bank field low
    assign o_sb_push     = {st_r.register_bank_select, st_r.memory_bank_select};
    assign o_work_bank   = st_r.work_bank;
    assign o_stack_flags = st_r.stk_flags;
    assign o_ram_addr    = st_r.addr;
    assign o_ram_bit     = st_r.bitn;
    assign o_ram_req     = st_r.req;
    assign o_ram_we      = st_r.we;
    assign o_acc_denied  = st_r.denied;
    assign o_rd_data     = st_r.rdata;
    assign o_rd_valid    = st_r.rd_vld;

    // Checks

    sequence s_read_denied;
        i_acc_req && !i_acc_wr ##1 o_acc_denied;
    endsequence

    sequence s_vec_entry;
        i_vec_take && !i_boot_load;
    endsequence

    property p_boot_emb;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_boot_load |=> o_emb == $past(i_vec_word[dmb_pkg::VEC_EMB_BIT]);
    endproperty
    a_boot_emb: assert property (p_boot_emb) else $error("emb not loaded at boot");

    property p_boot_erb;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_boot_load |=> o_erb == $past(i_vec_word[dmb_pkg::VEC_ERB_BIT]);
    endproperty
    a_boot_erb: assert property (p_boot_erb) else $error("erb not loaded at boot");

    property p_vec_load;
        @(posedge i_clk) disable iff (!i_rst_b)
        s_vec_entry |=> o_emb == $past(i_vec_word[dmb_pkg::VEC_EMB_BIT])
                        && o_stack_flags == $past({o_emb, o_erb});
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("vector entry flags wrong");

    property p_iret;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_iret && !i_vec_take && !i_boot_load |=> {o_emb, o_erb} == $past(i_iret_flags);
    endproperty
    a_iret: assert property (p_iret) else $error("flags not restored");

    property p_work_bank;
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_erb |-> o_work_bank == dmb_pkg::WORK_BANK_RST;
    endproperty
    a_work_bank: assert property (p_work_bank) else $error("working bank not 0");

    property p_smb_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        $changed(o_smb) |-> $past(i_smb_we || i_sb_pop);
    endproperty
    a_smb_hold: assert property (p_smb_hold) else $error("bank select changed alone");

    property p_direct_restrict;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_acc_req && !o_emb && i_acc_mode == dmb_pkg::MODE_DIRECT |=>
            o_ram_addr[11:8] == dmb_pkg::BANK0 || o_ram_addr[11:8] == dmb_pkg::BANK15;
    endproperty
    a_direct_restrict: assert property (p_direct_restrict) else $error("direct left window");

    property p_hl_bank;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_acc_req && o_emb && i_acc_mode == dmb_pkg::MODE_IND_HL |=>
            o_ram_addr[11:8] == $past(o_smb);
    endproperty
    a_hl_bank: assert property (p_hl_bank) else $error("bank not in top nibble");

    property p_wx_free;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_acc_req && i_acc_mode == dmb_pkg::MODE_IND_WX |=>
            !o_acc_denied && o_ram_req && o_ram_addr[11:8] == dmb_pkg::BANK0;
    endproperty
    a_wx_free: assert property (p_wx_free) else $error("pointer access refused");

    property p_denied_read;
        @(posedge i_clk) disable iff (!i_rst_b)
        s_read_denied |=> ##1 (o_rd_valid && o_rd_data == dmb_pkg::RDATA_ZERO);
    endproperty
    a_denied_read: assert property (p_denied_read) else $error("denied read not zero");

    property p_denied_nowrite;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_acc_denied |-> !o_ram_we && !o_ram_req;
    endproperty
    a_denied_nowrite: assert property (p_denied_nowrite) else $error("denied access wrote");

endmodule

// ---- core/dmb_pkg.sv ----
// Shared constants and types for the data memory bank addressing block
package dmb_pkg;

    // Memory bank numbers that the bank select field may hold
    localparam logic [3:0]  BANK0          = 4'h0;
    localparam logic [3:0]  BANK1          = 4'h1;
    localparam logic [3:0]  BANK2          = 4'h2;
    localparam logic [3:0]  BANK15         = 4'hF;

    // Low byte split: below it bank 0, from it up bank 15 (restricted direct)
    localparam logic [7:0]  DIRECT_SPLIT   = 8'h80;

    // Always reachable 1-bit direct areas, upper nibble of the low byte
    localparam logic [3:0]  MEMA_NIB_A     = 4'hB;
    localparam logic [3:0]  MEMA_NIB_B     = 4'hF;

    // Lowest address of the 1-bit indirect port area via L
    localparam logic [11:0] MEMB_BASE      = 12'hFC0;

    // Flag bit positions in a vector word
    localparam int          VEC_EMB_BIT    = 7;
    localparam int          VEC_ERB_BIT    = 6;

    // Bank select register layout: register bank field high, memory bank low
    localparam int          SB_SRB_MSB     = 7;
    localparam int          SB_SRB_LSB     = 4;
    localparam int          SB_SMB_MSB     = 3;
    localparam int          SB_SMB_LSB     = 0;

    // Reset values
    localparam logic [3:0]  SRB_RST        = 4'h0;
    localparam logic [3:0]  SMB_RST        = 4'h0;
    localparam logic [1:0]  WORK_BANK_RST  = 2'h0;
    localparam logic [7:0]  RDATA_ZERO     = 8'h00;

    // Flag selector for bit set and clear
    localparam logic        FLAG_SEL_EMB   = 1'b0;
    localparam logic        FLAG_SEL_ERB   = 1'b1;

    // Access modes
    typedef enum logic [2:0] {
        MODE_DIRECT     = 3'b000,
        MODE_IND_HL     = 3'b001,
        MODE_IND_WX     = 3'b010,
        MODE_IND_WL     = 3'b011,
        MODE_IND_SP     = 3'b100,
        MODE_BIT_MEMA   = 3'b101,
        MODE_BIT_MEMB_L = 3'b110,
        MODE_BIT_H_DA   = 3'b111
    } dmb_mode_t;

endpackage

// ---- testbench/dmb_bank_addr_tb_top.sv ----
// Self-checking bench for the data memory bank addressing block
`timescale 1ns/10ps
module dmb_bank_addr_tb_top;
    logic clk, rst_b, boot, vtake, iret, fwe, fsel, fval, smbwe, srbwe, pop, req, wr, byt;
    logic [7:0] vword, popd, da, sp, rdata, sbpush, rdd;
    logic [1:0] iflags, srbval, bidx, wbank, sflags, rbit;
    logic [3:0] smbval, h, l, w, x, memory_bank_select, register_bank_select, m_smb;
    logic [9:0] memb;
    logic [11:0] raddr;
    logic memory_bank_enable_flag, register_bank_enable_flag, rreq, rwe, den, rdv, m_emb, m_erb;
    logic [1:0] m_srb;
    dmb_pkg::dmb_mode_t mode;
    int error_cnt, n_tests, cyc;

    dmb_bank_addr dmb_bank_addr_inst (.i_clk(clk), .i_rst_b(rst_b), .i_boot_load(boot),
        .i_vec_take(vtake), .i_vec_word(vword), .i_iret(iret), .i_iret_flags(iflags),
        .i_flag_we(fwe), .i_flag_sel(fsel), .i_flag_val(fval), .i_smb_we(smbwe),
        .i_smb_val(smbval), .i_srb_we(srbwe), .i_srb_val(srbval), .i_sb_pop(pop),
        .i_sb_pop_data(popd), .i_acc_req(req), .i_acc_wr(wr), .i_acc_mode(mode),
        .i_acc_byte(byt), .i_acc_da(da), .i_acc_memb(memb), .i_bit_idx(bidx), .i_reg_h(h),
        .i_reg_l(l), .i_reg_w(w), .i_reg_x(x), .i_sp(sp), .i_ram_rdata(rdata), .o_emb(memory_bank_enable_flag),
        .o_erb(register_bank_enable_flag), .o_smb(memory_bank_select), .o_srb(register_bank_select), .o_sb_push(sbpush), .o_work_bank(wbank),
        .o_stack_flags(sflags), .o_ram_addr(raddr), .o_ram_bit(rbit), .o_ram_req(rreq),
        .o_ram_we(rwe), .o_acc_denied(den), .o_rd_data(rdd), .o_rd_valid(rdv));
    dmb_ram_model dmb_ram_model_inst (.i_clk(clk), .i_rst_b(rst_b), .i_req(rreq),
        .i_we(rwe), .i_addr(raddr), .o_rdata(rdata));

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results;
        end
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ends a control pulse one cycle after it was raised
    task automatic fin;
        @(negedge clk);
        {boot, vtake, iret, fwe, smbwe, srbwe, pop} = '0;
    endtask

    task automatic chkst;
        chk({11'h0, memory_bank_enable_flag}, {11'h0, m_emb});
        chk({11'h0, register_bank_enable_flag}, {11'h0, m_erb});
        chk({8'h0, memory_bank_select}, {8'h0, m_smb});
        chk({8'h0, register_bank_select}, {10'h0, m_srb});
        chk({4'h0, sbpush}, {6'h0, m_srb, m_smb});
        chk({10'h0, wbank}, {10'h0, m_erb ? m_srb : 2'h0});
    endtask

    function automatic logic [3:0] lsmb(input logic [1:0] s);
        return (s == 2'h3) ? 4'hF : {2'h0, s};
    endfunction

    // Expected {permitted, address} from the flag and bank model
    function automatic logic [12:0] exp_acc(input logic [2:0] m, input logic b);
        logic [11:0] a;
        logic        ok;
        ok = 1'b1;
        case (m)
            3'd0: a = m_emb ? {m_smb, da} : {da[7] ? 4'hF : 4'h0, da};
            3'd1: a = {m_emb ? m_smb : 4'h0, h, l};
            3'd2: a = {4'h0, w, x};
            3'd3: a = {4'h0, w, l};
            3'd4: a = {4'h0, sp};
            3'd5: begin a = {4'hF, da}; ok = (da[7:4] == 4'hB) || (da[7:4] == 4'hF); end
            3'd6: begin a = {memb, l[3:2]}; ok = a >= 12'hFC0; end
            default: a = {m_emb ? m_smb : 4'h0, h, da[3:0]};
        endcase
        if (m_emb && m_smb == 4'hF && (m < 3'd2 || m == 3'd7) && !a[7]) ok = 1'b0;
        if (b) a[0] = 1'b0;
        return {ok, a};
    endfunction

    task automatic acc(input logic w_i, input logic [2:0] m_i, input logic b_i,
                       input logic [7:0] da_i, input logic [9:0] mb_i,
                       input logic [15:0] hlwx_i, input logic [7:0] sp_i);
        logic [12:0] e;
        @(negedge clk);
        req = 1'b1; wr = w_i; mode = dmb_pkg::dmb_mode_t'(m_i); byt = b_i; da = da_i;
        memb = mb_i; {h, l, w, x} = hlwx_i; sp = sp_i; bidx = da_i[1:0] ^ mb_i[1:0];
        e = exp_acc(m_i, b_i);
        // Access answer stands only in the cycle after the taking edge
        @(negedge clk);
        chk({11'h0, rreq}, {11'h0, e[12]});
        chk({11'h0, den}, {11'h0, !e[12]});
        chk({11'h0, rwe}, {11'h0, e[12] & w_i});
        if (e[12]) chk(raddr, e[11:0]);
        if (e[12] && m_i >= 3'd5) chk({10'h0, rbit}, {10'h0, m_i == 3'd6 ? l[1:0] : bidx});
        req = 1'b0;
        if (!w_i) begin
            repeat (2) @(negedge clk);
            chk({11'h0, rdv}, 12'h001);
            chk({4'h0, rdd}, {4'h0, e[12] ? (e[7:0] ^ 8'hA5) : 8'h00});
        end
    endtask

    task automatic setf(input logic s, input logic v);
        @(negedge clk);
        fwe = 1'b1; fsel = s; fval = v;
        fin;
        if (s) m_erb = v; else m_emb = v;
    endtask

    initial begin
        logic [31:0] r, q, p;
        logic [15:0] hv;
        logic        bb;
        {clk, boot, vtake, iret, fwe, fsel, fval, smbwe, srbwe, pop, req, wr, byt} = '0;
        {vword, popd, da, sp, iflags, srbval, smbval, h, l, w, x, memb, bidx} = '0;
        mode = dmb_pkg::MODE_DIRECT; rst_b = 1'b0; error_cnt = 0; n_tests = 0; cyc = 0;
        {m_emb, m_erb, m_smb, m_srb} = '0;
        r = $urandom(32'h463D);
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        chkst;
        // Flag loading from vector words, entry save and return
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            if (i < 2) boot = 1'b1; else vtake = 1'b1;
            vword = {i[1:0] ^ 2'h2, 6'h15};
            p = {30'h0, m_emb, m_erb};
            fin;
            if (i >= 2) chk({10'h0, sflags}, p[11:0]);
            {m_emb, m_erb} = i[1:0] ^ 2'h2;
            chkst;
        end
        @(negedge clk);
        iret = 1'b1; iflags = 2'b10;
        fin;
        {m_emb, m_erb} = 2'b10;
        chkst;
        // Every bank number offered, only legal ones taken
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            smbwe = 1'b1; smbval = i[3:0];
            fin;
            if (i < 3 || i == 15) m_smb = i[3:0];
            chkst;
        end
        // Flags changed while bank 15 is selected
        for (int i = 0; i < 4; i++) begin
            setf(i[0], i[1]);
            chkst;
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            srbwe = 1'b1; srbval = i[1:0]; fwe = 1'b1; fsel = 1'b1; fval = i[2];
            fin;
            m_srb = i[1:0]; m_erb = i[2];
            chkst;
        end
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            @(negedge clk);
            pop = 1'b1; popd = {2'h0, r[1:0], lsmb(r[3:2])};
            fin;
            m_srb = r[1:0]; m_smb = lsmb(r[3:2]);
            chkst;
        end
        // Window edges
        setf(1'b0, 1'b0);
        acc(1'b0, 3'd0, 1'b0, 8'h7F, 10'h0, 16'h0, 8'h0);
        acc(1'b1, 3'd0, 1'b0, 8'h80, 10'h0, 16'h0, 8'h0);
        acc(1'b0, 3'd5, 1'b0, 8'hB3, 10'h0, 16'h0, 8'h0);
        acc(1'b1, 3'd5, 1'b0, 8'hA3, 10'h0, 16'h0, 8'h0);
        acc(1'b0, 3'd6, 1'b0, 8'h00, 10'h3F0, 16'h0300, 8'h0);
        acc(1'b0, 3'd6, 1'b0, 8'h00, 10'h3EF, 16'h0E00, 8'h0);
        // Peripheral indirect access after enabling bank 15
        @(negedge clk);
        smbwe = 1'b1; smbval = 4'hF;
        fin;
        m_smb = 4'hF;
        chkst;
        setf(1'b0, 1'b1);
        acc(1'b0, 3'd1, 1'b0, 8'h00, 10'h0, 16'h7F00, 8'h0);
        acc(1'b0, 3'd1, 1'b0, 8'h00, 10'h0, 16'h8000, 8'h0);
        // Random accesses under random flag and bank settings
        for (int i = 0; i < 300; i++) begin
            r = $urandom;
            q = $urandom;
            p = $urandom;
            @(negedge clk);
            fwe = 1'b1; fsel = 1'b0; fval = r[0]; smbwe = 1'b1; smbval = lsmb(r[2:1]);
            fin;
            m_emb = r[0]; m_smb = lsmb(r[2:1]);
            bb = r[6] && (r[5:3] <= 3'd4);
            hv = p[15:0];
            // Byte operands kept even
            if (bb) begin hv[8] = 1'b0; hv[0] = 1'b0; end
            acc(r[7], r[5:3], bb, {q[7:1], q[0] & !bb}, q[17:8], hv, {q[25:19], q[18] & !bb});
        end
        results;
    end
endmodule

// ---- testbench/dmb_ram_model.sv ----
// Data RAM model on the far side of the address block
`timescale 1ns/10ps
module dmb_ram_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [11:0] i_addr,
    output logic      [7:0]  o_rdata
);
    logic [7:0] junk_r;
    // Read data one cycle after a read request, churning bits otherwise
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            junk_r  <= 8'h5A;
            o_rdata <= 8'h00;
        end else begin
            junk_r  <= junk_r + 8'h3B;
            o_rdata <= (i_req && !i_we) ? (i_addr[7:0] ^ 8'hA5) : ~junk_r;
        end
    end
endmodule
